// file: logic/sbrg_top.sv
// Serial bit-rate generator with AXI4-Lite register slave and receive-line majority sampler.
// Assumes the transmitter and receiver shift logic consume rate_tick and receive_level.
//
// Overview of operation
// - The counter is 8 bits by default and 16 bits when the wide-counter select bit is set.
// - The high and low divisor bytes set the reload period of a free-running timer.
// - In synchronous operation the high-speed select bit has no effect.
// - Async, 8-bit, low speed gives a bit rate of oscillator over 64 times divisor plus one.
// - Async 8-bit high speed or 16-bit low speed gives oscillator over 16 times divisor plus one.
// - Async 16-bit high speed and synchronous master give oscillator over 4 times divisor plus one.
// - The rate applies only as master; in slave operation no bit clock is generated.
// - A write to either divisor byte clears the running timer at once.
// - The receive line level is the majority of three samples.
// - In synchronous operation clock-source select set makes the port master, clear makes it slave.
`timescale 1ns/10ps
`include "sbrg_cfg.svh"
module sbrg_top import sbrg_pkg::*; #(
	parameter int SAMPLE_COUNT = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic receive_line,
	input wire logic shift_empty,
	input wire logic receive_idle,
	output logic rate_tick,
	output logic bit_tick,
	output logic receive_level,
	output logic port_master,
	output logic port_enable
);
	// ==========================================
	// Register storage
	logic [7:0] transmit_status_control;
	logic [7:0] receive_status_control;
	logic [7:0] rate_control;
	logic [7:0] divisor_low_byte;
	logic [7:0] divisor_high_byte;
	logic [4:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic w_strb0;
	logic w_held;
	sbrg_wstate_t wstate;
	logic do_write;
	logic div_write;

	function automatic logic mapped(input logic [4:0] a);
		mapped = (a == `SBRG_OFF_TXSC) || (a == `SBRG_OFF_RXSC) || (a == `SBRG_OFF_RATE) ||
			(a == `SBRG_OFF_DIVL) || (a == `SBRG_OFF_DIVH);
	endfunction

	assign do_write = aw_held && w_held && (wstate == SBRG_W_IDLE);
	assign div_write = do_write && w_strb0 && ((aw_addr == `SBRG_OFF_DIVL) || (aw_addr == `SBRG_OFF_DIVH));

	// ==========================================
	// Write channels: address and data taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 5'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && (wstate == SBRG_W_IDLE);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb0 <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb0 <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && (wstate == SBRG_W_IDLE);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate <= SBRG_W_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SBRG_RESP_OKAY;
		end else begin
			case (wstate)
				SBRG_W_IDLE: begin
					if (do_write) begin
						wstate <= SBRG_W_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= mapped(aw_addr) ? SBRG_RESP_OKAY : SBRG_RESP_SLVERR;
					end
				end
				SBRG_W_RESP: begin
					if (s_axi_bready) begin
						wstate <= SBRG_W_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wstate <= SBRG_W_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// Only byte lane 0 carries register data; status bits are read-only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmit_status_control <= `SBRG_TXSC_RST;
			receive_status_control <= `SBRG_RXSC_RST;
			rate_control <= `SBRG_RATE_RST;
			divisor_low_byte <= `SBRG_DIV_RST;
			divisor_high_byte <= `SBRG_DIV_RST;
		end else begin
			transmit_status_control[`SBRG_TX_SHIFT_EMPTY] <= shift_empty;
			rate_control[`SBRG_RC_IDLE] <= receive_idle;
			rate_control[`SBRG_RC_LINE] <= receive_level;
			if (do_write && w_strb0) begin
				case (aw_addr)
					`SBRG_OFF_TXSC: begin
						transmit_status_control[7:2] <= w_data[7:2];
						transmit_status_control[0] <= w_data[0];
					end
					`SBRG_OFF_RXSC: receive_status_control <= w_data[7:0];
					`SBRG_OFF_RATE: rate_control[5:3] <= w_data[5:3];
					`SBRG_OFF_DIVL: divisor_low_byte <= w_data[7:0];
					`SBRG_OFF_DIVH: divisor_high_byte <= w_data[7:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================
	// Read channel: one read in flight; unmapped addresses answer SLVERR with zero data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= SBRG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? SBRG_RESP_OKAY : SBRG_RESP_SLVERR;
			case (s_axi_araddr)
				`SBRG_OFF_TXSC: s_axi_rdata <= {24'h000000, transmit_status_control};
				`SBRG_OFF_RXSC: s_axi_rdata <= {24'h000000, receive_status_control};
				`SBRG_OFF_RATE: s_axi_rdata <= {24'h000000, rate_control};
				`SBRG_OFF_DIVL: s_axi_rdata <= {24'h000000, divisor_low_byte};
				`SBRG_OFF_DIVH: s_axi_rdata <= {24'h000000, divisor_high_byte};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Rate generator
	logic sync_mode;
	logic wide;
	logic hspeed;
	logic master;
	logic enabled;
	logic [15:0] reload;
	logic [15:0] count;
	logic [5:0] prescale;
	logic [1:0] ratio;
	logic [5:0] prescale_top;
	logic count_wrap;

	assign sync_mode = transmit_status_control[`SBRG_TX_SYNC];
	assign wide = rate_control[`SBRG_RC_WIDE];
	assign hspeed = transmit_status_control[`SBRG_TX_HSPEED];
	assign enabled = receive_status_control[`SBRG_RX_PORT_EN];
	assign master = !sync_mode || transmit_status_control[`SBRG_TX_CLKSRC];
	assign reload = wide ? {divisor_high_byte, divisor_low_byte} : {8'h00, divisor_low_byte};

	always_comb begin
		if (sync_mode) begin
			ratio = `SBRG_DIV4;
		end else if (!wide && !hspeed) begin
			ratio = `SBRG_DIV64;
		end else if (wide && hspeed) begin
			ratio = `SBRG_DIV4;
		end else begin
			ratio = `SBRG_DIV16;
		end
		case (ratio)
			`SBRG_DIV64: prescale_top = `SBRG_PRE64;
			`SBRG_DIV16: prescale_top = `SBRG_PRE16;
			default: prescale_top = `SBRG_PRE4;
		endcase
	end

	assign count_wrap = (count >= reload);

	// The divisor counts in prescaled units so the timer itself stays divisor-wide.
	always_ff @(posedge aclk) begin
		if (!aresetn || !enabled || !master || div_write) begin
			prescale <= 6'h00;
			count <= 16'h0000;
			bit_tick <= 1'b0;
		end else if (prescale >= prescale_top) begin
			prescale <= 6'h00;
			bit_tick <= count_wrap;
			count <= count_wrap ? 16'h0000 : count + 16'h0001;
		end else begin
			prescale <= prescale + 6'h01;
			bit_tick <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rate_tick <= 1'b0;
			port_master <= 1'b0;
			port_enable <= 1'b0;
		end else begin
			rate_tick <= enabled && master && !div_write && (prescale >= prescale_top) && count_wrap;
			port_master <= enabled && master;
			port_enable <= enabled;
		end
	end

	// ==========================================
	// Receive-line majority sampler
	logic [SAMPLE_COUNT-1:0] samples;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samples <= '1;
			receive_level <= 1'b1;
		end else begin
			samples <= {samples[SAMPLE_COUNT-2:0], receive_line};
			receive_level <= (samples[0] & samples[1]) | (samples[0] & samples[2]) |
				(samples[1] & samples[2]);
		end
	end

	// ==========================================
	// Checks
	sequence div_wr_s;
		div_write;
	endsequence

	timer_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		div_wr_s |=> (count == 16'h0000) && (prescale == 6'h00))
		else $error("Timer not cleared after divisor write.");
	narrow_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wide |-> reload[15:8] == 8'h00)
		else $error("High divisor byte used in 8-bit mode.");
	wide_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wide |-> reload == {divisor_high_byte, divisor_low_byte})
		else $error("16-bit reload not formed from both bytes.");
	sync_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_mode |-> prescale_top == 6'h03)
		else $error("Synchronous ratio not divide by four.");
	slow_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && !wide && !hspeed) |-> prescale_top == 6'h3F)
		else $error("Low-speed 8-bit ratio not 64.");
	mid_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && (wide ^ hspeed)) |-> prescale_top == 6'h0F)
		else $error("Middle ratio not 16.");
	fast_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && wide && hspeed) |-> prescale_top == 6'h03)
		else $error("Fast ratio not 4.");
	slave_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_mode && !transmit_status_control[`SBRG_TX_CLKSRC]) |=> !rate_tick)
		else $error("Rate tick in slave operation.");
	majority_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(samples[1:0] == 2'b11) |=> receive_level)
		else $error("Majority vote missed two high samples.");
	// Any register write may move the timer phase, so the period check needs four quiet cycles.
	sequence fast_quiet_s;
		(rate_tick && !do_write && enabled && master && sync_mode && reload == 16'h0000) ##1 !do_write [*3];
	endsequence

	free_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fast_quiet_s |=> rate_tick && !$past(rate_tick) && !$past(rate_tick, 2) && !$past(rate_tick, 3))
		else $error("Timer period wrong for divisor zero.");

	// Ticks are single pulses and stay off while the port is off or the timer restarts.
	restart_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		div_wr_s |=> !rate_tick && !bit_tick)
		else $error("Tick right after a divisor write.");
	tick_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rate_tick |=> !rate_tick)
		else $error("Rate tick longer than one cycle.");
	tick_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rate_tick == bit_tick)
		else $error("Bit tick and rate tick disagree.");
	disabled_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!enabled |=> !rate_tick && !port_master)
		else $error("Tick or master while the port is disabled.");
	async_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && enabled) |=> port_master)
		else $error("Asynchronous port not master.");
	master_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_mode && transmit_status_control[`SBRG_TX_CLKSRC] && enabled) |=> port_master)
		else $error("Synchronous port with internal clock not master.");
	slave_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sync_mode && !transmit_status_control[`SBRG_TX_CLKSRC]) |=> !port_master)
		else $error("Synchronous port with external clock still master.");
	majority_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(samples[1:0] == 2'b00) |=> !receive_level)
		else $error("Majority vote missed two low samples.");
endmodule // sbrg_top

// file: pkg/sbrg_cfg.svh
// Constants of the serial rate generator: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`ifndef SBRG_CFG_SVH
`define SBRG_CFG_SVH
// ==========================================
// Register byte offsets
`define SBRG_OFF_TXSC 5'h00
`define SBRG_OFF_RXSC 5'h04
`define SBRG_OFF_RATE 5'h08
`define SBRG_OFF_DIVL 5'h0C
`define SBRG_OFF_DIVH 5'h10
// ==========================================
// Field positions
`define SBRG_TX_CLKSRC 7
`define SBRG_TX_SYNC 4
`define SBRG_TX_HSPEED 2
`define SBRG_TX_SHIFT_EMPTY 1
`define SBRG_RX_PORT_EN 7
`define SBRG_RC_IDLE 6
`define SBRG_RC_WIDE 3
`define SBRG_RC_LINE 2
// ==========================================
// Reset values
`define SBRG_TXSC_RST 8'h02
`define SBRG_RXSC_RST 8'h00
`define SBRG_RATE_RST 8'h40
`define SBRG_DIV_RST 8'h00
// ==========================================
// Divide ratios per count
`define SBRG_DIV64 2'h0
`define SBRG_DIV16 2'h1
`define SBRG_DIV4 2'h2
// ==========================================
// Prescaler end counts, one less than each divide ratio.
`define SBRG_PRE64 6'h3F
`define SBRG_PRE16 6'h0F
`define SBRG_PRE4 6'h03
`endif

// file: pkg/sbrg_pkg.sv
// Types of the serial rate generator.
// Assumes the constants header sbrg_cfg.svh alongside.
package sbrg_pkg;
	typedef enum logic [1:0] {
		SBRG_RESP_OKAY = 2'h0,
		SBRG_RESP_SLVERR = 2'h2
	} sbrg_resp_t;
	typedef enum logic [1:0] {
		SBRG_W_IDLE = 2'b01,
		SBRG_W_RESP = 2'b10
	} sbrg_wstate_t;
endpackage

// file: tb/sbrg_shift_model.sv
// Partner model of the shift logic that consumes the generated bit clock.
// Assumes one clock domain and a one-cycle send pulse from the bench.
`timescale 1ns/10ps
module sbrg_shift_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rate_tick,
	input wire logic send,
	output logic shift_empty,
	output logic receive_idle
);
	logic [3:0] left;
	// ==========================================
	// Frame counter.
	// Ten bit periods per frame, so busy lasts as long as the rate says.
	always_ff @(posedge aclk) begin
		if (!aresetn) left <= 4'h0;
		else if (send) left <= 4'hA;
		else if (rate_tick && left != 4'h0) left <= left - 4'h1;
	end
	assign shift_empty = (left == 4'h0);
	assign receive_idle = shift_empty;
endmodule // sbrg_shift_model

// file: tb/tb_top.sv
// Self-checking bench of the serial rate generator.
// Assumes the design's AXI4-Lite slave and the shift logic model.
`timescale 1ns/10ps
`include "sbrg_cfg.svh"
module tb_top import sbrg_pkg::*;;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rx = 1, send = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, seed = 32'h1697136C;
	logic [3:0] strb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, tick, btick, lvl, mst, pen, sempty, ridle;
	logic [1:0] bresp, rresp;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0, tests_run = 0;
	int ratio [7] = '{64, 16, 16, 4, 4, 4, 4};
	logic [7:0] txv [7] = '{8'h80, 8'h84, 8'h80, 8'h84, 8'h90, 8'h94, 8'h94};
	logic [7:0] rtv [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08};
	sbrg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .receive_line(rx),
		.shift_empty(sempty), .receive_idle(ridle), .rate_tick(tick), .bit_tick(btick),
		.receive_level(lvl), .port_master(mst), .port_enable(pen));
	sbrg_shift_model peer (.aclk(aclk), .aresetn(aresetn), .rate_tick(tick), .send(send),
		.shift_empty(sempty), .receive_idle(ridle));
	// ==========================================
	// Checking.
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string n, input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task report_and_stop;
		if (miscompares == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
	end
	// ==========================================
	// Bus cycles; each request is held until its own ready.
	task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		bq.push_back(er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		rq.push_back({er, 24'h0, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	// The first interval after a change is skipped, since the timer phase is unknown.
	task period(input int e);
		int n;
		logic pb;
		n = 0;
		do @(posedge aclk); while (!tick);
		do begin
			@(posedge aclk);
			n++;
			pb = btick;
		end while (!tick);
		chk("period", e, n);
		chk("bit_tick", 1, pb);
	endtask
	task glitch(input logic v);
		rx <= v;
		repeat (6 + 32'(rnd() & 32'h7)) @(posedge aclk);
		rx <= ~v;
		@(posedge aclk);
		rx <= v;
		repeat (5) begin
			@(posedge aclk);
			chk("receive_level", v, lvl);
		end
	endtask
	// ==========================================
	// Stimulus.
	initial forever #2 aclk = ~aclk;
	initial begin
		#200000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		logic [7:0] lo;
		int n;
		lo = 8'(rnd() & 32'h7);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(`SBRG_OFF_TXSC, 8'h02, SBRG_RESP_OKAY);
		rd(`SBRG_OFF_RXSC, 8'h00, SBRG_RESP_OKAY);
		rd(`SBRG_OFF_DIVH, 8'h00, SBRG_RESP_OKAY);
		rd(5'h14, 8'h00, SBRG_RESP_SLVERR);
		wr(5'h14, 8'h55, SBRG_RESP_SLVERR);
		strb <= 4'h0;
		wr(`SBRG_OFF_DIVL, 8'hAA, SBRG_RESP_OKAY);
		strb <= 4'hF;
		rd(`SBRG_OFF_DIVL, 8'h00, SBRG_RESP_OKAY);
		wr(`SBRG_OFF_RXSC, 8'h80, SBRG_RESP_OKAY);
		@(posedge aclk);
		chk("port_enable", 1, pen);
		wr(`SBRG_OFF_DIVH, 8'h01, SBRG_RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			wr(`SBRG_OFF_TXSC, txv[i], SBRG_RESP_OKAY);
			wr(`SBRG_OFF_RATE, rtv[i], SBRG_RESP_OKAY);
			wr(`SBRG_OFF_DIVL, lo, SBRG_RESP_OKAY);
			chk("port_master", 1, mst);
			period(ratio[i] * ((rtv[i][3] ? 256 : 0) + lo + 1));
		end
		wr(`SBRG_OFF_RATE, 8'h00, SBRG_RESP_OKAY);
		wr(`SBRG_OFF_DIVL, 8'h00, SBRG_RESP_OKAY);
		period(4);
		rd(`SBRG_OFF_DIVH, 8'h01, SBRG_RESP_OKAY);
		wr(`SBRG_OFF_TXSC, 8'h10, SBRG_RESP_OKAY);
		@(posedge aclk);
		chk("port_master", 0, mst);
		n = 0;
		repeat (600) begin
			@(posedge aclk);
			if (tick) n++;
		end
		chk("slave_ticks", 0, n);
		wr(`SBRG_OFF_TXSC, 8'h80, SBRG_RESP_OKAY);
		wr(`SBRG_OFF_RATE, 8'h00, SBRG_RESP_OKAY);
		wr(`SBRG_OFF_DIVL, 8'hFF, SBRG_RESP_OKAY);
		repeat (400) @(posedge aclk);
		wr(`SBRG_OFF_DIVL, 8'h01, SBRG_RESP_OKAY);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!tick && n < 200);
		chk("restart", 1, n >= 120 && n <= 130);
		period(128);
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		rd(`SBRG_OFF_TXSC, 8'h80, SBRG_RESP_OKAY);
		rd(`SBRG_OFF_RATE, 8'h04, SBRG_RESP_OKAY);
		repeat (1400) @(posedge aclk);
		rd(`SBRG_OFF_TXSC, 8'h82, SBRG_RESP_OKAY);
		glitch(1'b1);
		glitch(1'b0);
		glitch(1'b1);
		report_and_stop;
	end
endmodule // tb_top
